// ---- logic/pslp_pkg.sv ----
// Constants shared by the strap latch and status LED logic.
// Assumes a 32-bit APB register window and a 20 MHz system clock.
package pslp_pkg;

   // Clock rate and the visible activity blink time.
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned ACT_BLINK_MS = 20;
   localparam int unsigned ACT_BLINK_CYC = CLK_HZ / 1000 * ACT_BLINK_MS;

   // Register byte offsets.
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STRAP_OFS = 8'h04;
   localparam logic [7:0] STATUS_OFS = 8'h08;
   localparam logic [7:0] LEDCFG_OFS = 8'h0c;

   // Basic control register field positions.
   localparam int unsigned CTRL_SPEED_BIT = 13;
   localparam int unsigned CTRL_ANEG_BIT = 12;
   localparam int unsigned CTRL_DUPLEX_BIT = 8;
   localparam logic [15:0] CTRL_WR_MASK = 16'h3100;

   // Strap register field positions.
   localparam int unsigned STRAP_ADDR_LSB = 0;
   localparam int unsigned STRAP_BTB_BIT = 5;
   localparam int unsigned STRAP_RMII_BIT = 6;

   // Status register field positions.
   localparam int unsigned STAT_LINK_BIT = 0;
   localparam int unsigned STAT_SPD_BIT = 1;
   localparam int unsigned STAT_FDX_BIT = 2;
   localparam int unsigned STAT_COL_BIT = 3;
   localparam int unsigned STAT_LED_LSB = 4;

   // Reset values.
   localparam logic [15:0] CTRL_RST = 16'h3100;
   localparam logic [4:0] STATION_ADDR_RST = 5'h01;
   localparam logic LEDCFG_RST = 1'b0;

endpackage : pslp_pkg

// ---- logic/pslp_led_if.sv ----
// Carrier between the strap latch top and the LED driver.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface pslp_led_if;
   logic link_up;
   logic activity;
   logic speed_100;
   logic full_duplex;
   logic collision;
   logic leds_off;
   logic [3:0] led_level;

   modport ctl
   (
      output link_up,
      output activity,
      output speed_100,
      output full_duplex,
      output collision,
      output leds_off,
      input led_level
   );

   modport drv
   (
      input link_up,
      input activity,
      input speed_100,
      input full_duplex,
      input collision,
      input leds_off,
      output led_level
   );
endinterface : pslp_led_if

// ---- logic/pslp_led_drive.sv ----
// Status LED driver: link/activity, speed, duplex and collision levels.
// Assumes status inputs are synchronous to mclk; LEDs are active low.
`timescale 1ns/10ps
module pslp_led_drive
   import pslp_pkg::*;
#(
   parameter int unsigned BLINK_CYC = ACT_BLINK_CYC
)
(
   input wire logic mclk,
   input wire logic sys_rst,
   pslp_led_if.drv led
);

   initial
   begin
      if (BLINK_CYC < 1)
         $error("BLINK_CYC must be at least one cycle.");
   end

   localparam int unsigned CW = $clog2(BLINK_CYC + 1);

   logic [CW-1:0] blink_cnt_reg;
   logic [CW-1:0] blink_cnt_next;
   logic blink_reg;
   logic act_seen_reg;
   logic blink_tick;
   logic [3:0] level_next;
   logic [3:0] level_reg;

   // The divider runs freely and the blink only toggles at its tick after activity was seen, so a busy link blinks
   // at a visible rate instead of flickering at frame rate.
   assign blink_tick = (blink_cnt_reg == CW'(BLINK_CYC - 1));
   assign blink_cnt_next = blink_tick ? '0 : blink_cnt_reg + 1'b1;

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         blink_cnt_reg <= '0;
         blink_reg <= 1'b0;
         act_seen_reg <= 1'b0;
      end
      else
      begin
         blink_cnt_reg <= blink_cnt_next;
         act_seen_reg <= (act_seen_reg & ~blink_tick) | led.activity;
         if (blink_tick)
            blink_reg <= act_seen_reg & ~blink_reg;
      end
   end

   // Pin levels: high means off, low means on.
   assign level_next[0] = led.leds_off | ~led.link_up | blink_reg;
   assign level_next[1] = led.leds_off | ~led.speed_100;
   assign level_next[2] = led.leds_off | ~led.full_duplex;
   assign level_next[3] = led.leds_off | ~led.collision;

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         level_reg <= 4'hf;
      else
         level_reg <= level_next;
   end

   assign led.led_level = level_reg;

endmodule : pslp_led_drive

// ---- logic/pslp_strap_top.sv ----
// Strap latch and dual-use pin control for a 10/100 transceiver.
// Assumes pad pulls sit outside; pins are synchronous to mclk.
//
// How it works
// - Pull-up pins are inputs in reset, outputs after.
// - Interrupt pin level latched as station_addr_bit0.
// - Unstrapped station address defaults to 00001.
// - Reduced mode latches carrier pin as back_to_back.
// - speed_led level latched into control bit 13.
// - speed_led high at 10, low at 100.
// - duplex_led level latched into control bit 8.
// - duplex_led high half duplex, low full duplex.
// - collision_led level latched into control bit 12.
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/10ps
module pslp_strap_top
   import pslp_pkg::*;
#(
   parameter int unsigned BLINK_CYC = ACT_BLINK_CYC
)
(
   input wire logic mclk,
   input wire logic sys_rst,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Dual-use pins: input, output, output enable.
   input wire logic event_alert_n_in,
   output logic event_alert_n_out,
   output logic event_alert_n_oe,
   input wire logic carrier_sense_in,
   output logic carrier_sense_out,
   output logic carrier_sense_oe,
   input wire logic [3:0] led_in,
   output logic [3:0] led_out,
   output logic [3:0] led_oe,
   // Other straps latched elsewhere but needed here.
   input wire logic [3:0] station_addr_hi_strap,
   input wire logic reduced_iface_select,
   // Core status.
   input wire logic link_up,
   input wire logic activity,
   input wire logic speed_100,
   input wire logic full_duplex,
   input wire logic collision,
   input wire logic carrier,
   input wire logic event_pending,
   // Latched configuration towards the core.
   output logic [4:0] station_addr,
   output logic reduced_iface_back_to_back,
   output logic speed_strap,
   output logic duplex_strap,
   output logic autoneg_enable_bit
);

   pslp_led_if led_bus ();

   logic [4:0] addr_reg;
   logic btb_reg;
   logic rmii_reg;
   logic [15:0] ctrl_reg;
   logic [15:0] ctrl_next;
   logic leds_off_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic setup_ph;
   logic wr_en;
   logic addr_ok;
   logic pins_out_reg;

   // A pin index of the LED group by name.
   localparam int unsigned LED_LNK = 0;
   localparam int unsigned LED_SPD = 1;
   localparam int unsigned LED_DUP = 2;
   localparam int unsigned LED_COL = 3;

   // Straps follow the pins for every cycle of reset and freeze at its
   // release, so the last level seen before release is the one kept.
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         addr_reg <= {station_addr_hi_strap, event_alert_n_in};
         rmii_reg <= reduced_iface_select;
         btb_reg <= reduced_iface_select & carrier_sense_in;
      end
   end

   // Control register: reset preset from the LED pins, then writable.
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         ctrl_reg <= CTRL_RST;
         ctrl_reg[CTRL_SPEED_BIT] <= led_in[LED_SPD];
         ctrl_reg[CTRL_DUPLEX_BIT] <= led_in[LED_DUP];
         ctrl_reg[CTRL_ANEG_BIT] <= led_in[LED_COL];
         leds_off_reg <= LEDCFG_RST;
      end
      else if (wr_en)
      begin
         if (paddr == CTRL_OFS)
            ctrl_reg <= ctrl_next;
         if (paddr == LEDCFG_OFS)
            leds_off_reg <= pwdata[0];
      end
   end

   assign ctrl_next = (ctrl_reg & ~CTRL_WR_MASK) |
                      (pwdata[15:0] & CTRL_WR_MASK);

   // Output enables come up one edge after release so strap sampling and
   // pin driving never overlap.
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         pins_out_reg <= 1'b0;
      else
         pins_out_reg <= 1'b1;
   end

   // Pull-up and pull-down pins float while in reset.
   assign event_alert_n_oe = pins_out_reg;
   assign carrier_sense_oe = pins_out_reg;
   assign led_oe = {4{pins_out_reg}};

   // Pin levels after reset; the LED driver holds all high in reset, which
   // also keeps the link LED pin away from its factory test level.
   assign event_alert_n_out = ~event_pending;
   assign carrier_sense_out = carrier;
   assign led_out = led_bus.led_level;

   // Status into the LED driver.
   assign led_bus.link_up = link_up;
   assign led_bus.activity = activity;
   assign led_bus.speed_100 = speed_100;
   assign led_bus.full_duplex = full_duplex;
   assign led_bus.collision = collision;
   assign led_bus.leds_off = leds_off_reg;

   pslp_led_drive #(
      .BLINK_CYC(BLINK_CYC)
   ) u_led (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .led(led_bus)
   );

   // Latched configuration to the core.
   assign station_addr = addr_reg;
   assign reduced_iface_back_to_back = btb_reg;
   assign speed_strap = ctrl_reg[CTRL_SPEED_BIT];
   assign duplex_strap = ctrl_reg[CTRL_DUPLEX_BIT];
   assign autoneg_enable_bit = ctrl_reg[CTRL_ANEG_BIT];

   // APB decode: zero wait states, unmapped offsets answer with an error.
   assign setup_ph = psel & ~penable;
   assign addr_ok = (paddr == CTRL_OFS) | (paddr == STRAP_OFS) |
                    (paddr == STATUS_OFS) | (paddr == LEDCFG_OFS);
   assign wr_en = psel & penable & pwrite & addr_ok;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;

   // Read data is captured in the setup phase so it comes from a flop.
   always_comb
   begin
      rdata_next = 32'h0000_0000;
      case (paddr)
         CTRL_OFS: rdata_next[15:0] = ctrl_reg;
         STRAP_OFS:
         begin
            rdata_next[STRAP_ADDR_LSB +: 5] = addr_reg;
            rdata_next[STRAP_BTB_BIT] = btb_reg;
            rdata_next[STRAP_RMII_BIT] = rmii_reg;
         end
         STATUS_OFS:
         begin
            rdata_next[STAT_LINK_BIT] = link_up;
            rdata_next[STAT_SPD_BIT] = speed_100;
            rdata_next[STAT_FDX_BIT] = full_duplex;
            rdata_next[STAT_COL_BIT] = collision;
            rdata_next[STAT_LED_LSB +: 4] = led_bus.led_level;
         end
         LEDCFG_OFS: rdata_next[0] = leds_off_reg;
         default: rdata_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         rdata_reg <= 32'h0000_0000;
      else if (setup_ph)
         rdata_reg <= rdata_next;
   end

   assign prdata = rdata_reg;

endmodule : pslp_strap_top

// ---- test/pslp_board.sv ----
// Board model: strap pulls on the dual-use pins.
// Assumes the device drives a pin only while its enable is high.
`timescale 1ns/10ps
module pslp_board
(
   input wire logic [5:0] drv,
   input wire logic [5:0] oe,
   input wire logic [5:1] pull,
   output logic [5:0] lvl
);
   // Released pins settle to the board pull. Bit 0, the link LED, only has
   // a pull-up, because a pull-down there selects a factory mode.
   assign lvl = (oe & drv) | (~oe & {pull, 1'h1});
endmodule : pslp_board

// ---- test/pslp_strap_top_assertions.sv ----
// Port checks for the strap latch top, attached by bind.
// Assumes the single clock mclk and a synchronous reset.
`timescale 1ns/10ps
module pslp_strap_top_assertions
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic event_alert_n_in,
   input wire logic event_alert_n_oe,
   input wire logic carrier_sense_in,
   input wire logic carrier_sense_oe,
   input wire logic [3:0] led_in,
   input wire logic [3:0] led_out,
   input wire logic [3:0] led_oe,
   input wire logic [3:0] station_addr_hi_strap,
   input wire logic reduced_iface_select,
   input wire logic link_up,
   input wire logic speed_100,
   input wire logic full_duplex,
   input wire logic collision,
   input wire logic [4:0] station_addr,
   input wire logic reduced_iface_back_to_back,
   input wire logic speed_strap,
   input wire logic duplex_strap,
   input wire logic autoneg_enable_bit
);
   logic was_run;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);
   // Marks edges whose previous edge was out of reset; LEDs lag one edge.
   always_ff @(posedge mclk)
      was_run <= !sys_rst;
   sequence s_rel;
      $fell(sys_rst);
   endsequence
   property p_oe;
      s_rel |=> &{led_oe, event_alert_n_oe, carrier_sense_oe};
   endproperty
   a_oe: assert property (p_oe) else $error("pins not driven");
   // Strap checks look at reset edges, so they are never disabled.
   property p_addr;
      disable iff (1'h0) sys_rst |=>
         station_addr == $past({station_addr_hi_strap, event_alert_n_in});
   endproperty
   a_addr: assert property (p_addr) else $error("address");
   property p_btb;
      disable iff (1'h0) sys_rst && reduced_iface_select |=>
         reduced_iface_back_to_back == $past(carrier_sense_in);
   endproperty
   a_btb: assert property (p_btb) else $error("back to back");
   property p_ctl;
      disable iff (1'h0) sys_rst |=> {speed_strap, duplex_strap,
         autoneg_enable_bit} == $past({led_in[1], led_in[2], led_in[3]});
   endproperty
   a_ctl: assert property (p_ctl) else $error("ctrl strap");
   property p_spd;
      was_run |-> led_out[1] == !$past(speed_100);
   endproperty
   a_spd: assert property (p_spd) else $error("speed led");
   property p_dpx;
      was_run |-> led_out[2] == !$past(full_duplex);
   endproperty
   a_dpx: assert property (p_dpx) else $error("duplex led");
   property p_col;
      was_run |-> led_out[3] == !$past(collision);
   endproperty
   a_col: assert property (p_col) else $error("collision led");
   property p_lnk;
      was_run && !$past(link_up) |-> led_out[0];
   endproperty
   a_lnk: assert property (p_lnk) else $error("link led");
endmodule : pslp_strap_top_assertions
bind pslp_strap_top pslp_strap_top_assertions i_chk (.*);

// ---- test/pslp_strap_top_tb_top.sv ----
// Self-checking bench for the strap latch and status LED top.
// Assumes the board model resolves every dual-use pin level.
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module pslp_strap_top_tb_top
   import pslp_pkg::*;
;
   localparam int unsigned BLK = 4;
   logic mclk = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0;
   logic pwrite = 1'h0, pready, pslverr, er, seen;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic event_alert_n_in, event_alert_n_out, event_alert_n_oe;
   logic carrier_sense_in, carrier_sense_out, carrier_sense_oe;
   logic [3:0] led_in, led_out, led_oe, exp4, station_addr_hi_strap = 4'h0;
   logic reduced_iface_select = 1'h0, link_up = 1'h0, activity = 1'h0;
   logic speed_100 = 1'h0, full_duplex = 1'h0, collision = 1'h0;
   logic carrier = 1'h0, event_pending = 1'h0, reduced_iface_back_to_back;
   logic speed_strap, duplex_strap, autoneg_enable_bit;
   logic [4:0] station_addr;
   logic [5:1] pull = 5'h1f;
   logic [5:0] lvl;
   int err_count = 0, checks = 0, rnd;
   // Device, and the board that sets pin levels while pins are released.
   assign {carrier_sense_in, event_alert_n_in, led_in} = lvl;
   pslp_strap_top #(.BLINK_CYC(BLK)) i_dut (.*);
   pslp_board i_brd (.drv({carrier_sense_out, event_alert_n_out, led_out}),
      .oe({carrier_sense_oe, event_alert_n_oe, led_oe}), .pull(pull),
      .lvl(lvl));
   initial
   begin
      forever #25 mclk = ~mclk;
   end
   task automatic final_report;
      $display("Mismatches %0d, checks %0d", err_count, checks);
      if (err_count == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : final_report
   // One APB transfer; waits for pready but never past a fixed bound.
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge mclk);
      {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
      @(posedge mclk);
      penable <= 1'h1;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'h1 && n < 16);
      r = prdata;
      e = pslverr;
      {psel, penable} <= 2'h0;
      if (n >= 16)
      begin
         err_count++;
         final_report();
      end
   endtask : apb
   // Reset with given pulls, then check every latched strap.
   task automatic do_reset(input logic [5:1] p, input logic [3:0] h,
      input logic s);
      {pull, station_addr_hi_strap, reduced_iface_select, sys_rst} <=
         {p, h, s, 1'h1};
      repeat (7) @(posedge mclk);
      #1 `CHK({led_oe, led_out}, 8'h0f)
      @(posedge mclk);
      sys_rst <= 1'h0;
      @(posedge mclk);
      #1 `CHK({led_oe, event_alert_n_oe, carrier_sense_oe}, 6'h3f)
      `CHK(station_addr, {h, p[4]})
      if (s)
         `CHK(reduced_iface_back_to_back, p[5])
      apb(1'h0, CTRL_OFS, 32'h0, rd, er);
      `CHK(rd, {18'h0, p[1], p[3], 3'h0, p[2], 8'h0})
      apb(1'h0, STRAP_OFS, 32'h0, rd, er);
      `CHK(rd & {26'h1, s, 5'h1f}, {25'h0, s, s & p[5], h, p[4]})
   endtask : do_reset
   initial
   begin
      rnd = $urandom(32'h103d);
      do_reset(5'h1f, 4'h0, 1'h0);
      do_reset(5'h00, 4'hf, 1'h1);
      repeat (6) do_reset(5'($urandom), 4'($urandom), 1'($urandom));
      // Random status, no activity: each LED is low while its cause holds.
      repeat (40)
      begin
         @(posedge mclk);
         {link_up, speed_100, full_duplex, collision, carrier,
            event_pending} <= 6'($urandom);
         @(posedge mclk);
         exp4 = ~{collision, full_duplex, speed_100, link_up};
         #1 `CHK(led_out, exp4)
         // The interrupt and carrier pins pass core status straight out after reset.
         `CHK({event_alert_n_out, carrier_sense_out},
            {~event_pending, carrier})
      end
      // Status word mirrors the core inputs and the LED pin levels.
      apb(1'h0, STATUS_OFS, 32'h0, rd, er);
      `CHK(rd, {24'h0, exp4, collision, full_duplex, speed_100,
         link_up})
      // Activity on a live link must blink once, then settle low again.
      @(posedge mclk);
      {link_up, activity} <= 2'h3;
      @(posedge mclk);
      activity <= 1'h0;
      seen = 1'h0;
      repeat (3 * BLK + 4)
      begin
         @(posedge mclk);
         seen = seen | led_out[0];
      end
      `CHK({seen, led_out[0]}, 2'h2)
      // Only the strap-backed control bits are writable.
      apb(1'h1, CTRL_OFS, 32'hffffffff, rd, er);
      apb(1'h0, CTRL_OFS, 32'h0, rd, er);
      `CHK({er, rd}, {17'h0, CTRL_WR_MASK})
      apb(1'h1, CTRL_OFS, 32'h0, rd, er);
      // The write lands at the access edge; look once it has settled.
      #1 `CHK({speed_strap, duplex_strap, autoneg_enable_bit}, 3'h0)
      apb(1'h0, 8'h40, 32'h0, rd, er);
      `CHK({er, rd}, 33'h100000000)
      final_report();
   end
endmodule : pslp_strap_top_tb_top
